// ===== button_panel.sv
`timescale 1ns/1ns
module button_panel #(
  parameter int HOLD = 3
)
(
  // Clock
  input wire logic clock,
  // Press commands
  input wire logic upCmd,
  input wire logic downCmd,
  // Button levels
  output logic speedUpBtn,
  output logic speedDownBtn
);
  logic upQ = 1'h0; // Which button is held
  logic downQ = 1'h0;
  int holdCnt = 0; // Cycles left pressed
  // A press holds the level, then it drops so presses stay apart
  always @(posedge clock)
  begin
    if (upCmd || downCmd)
    begin
      upQ <= upCmd;
      downQ <= downCmd;
      holdCnt <= HOLD;
    end
    else if (holdCnt != 0)
      holdCnt <= holdCnt - 1;
  end
  assign speedUpBtn = upQ && (holdCnt != 0);
  assign speedDownBtn = downQ && (holdCnt != 0);
endmodule : button_panel

// ===== drive_profile_pkg.sv
package drive_profile_pkg;

  // Storage geometry
  localparam int MAX_PROFILES = 5;
  localparam int NUM_FIELDS = 15;
  localparam int PAR_W = 7;
  localparam int CUR_W = 8;
  localparam int ADDR_W = 7;

  // Per-profile field indices; word address is profile * PROFILE_STRIDE + field
  localparam logic [3:0] F_ACCEL = 4'h0;
  localparam logic [3:0] F_DECEL = 4'h1;
  localparam logic [3:0] F_TACCEL = 4'h2;
  localparam logic [3:0] F_TDECEL = 4'h3;
  localparam logic [3:0] F_FWDMIN = 4'h4;
  localparam logic [3:0] F_FWDMAX = 4'h5;
  localparam logic [3:0] F_REVMIN = 4'h6;
  localparam logic [3:0] F_REVMAX = 4'h7;
  localparam logic [3:0] F_TURNMIN = 4'h8;
  localparam logic [3:0] F_TURNMAX = 4'h9;
  localparam logic [3:0] F_POWER = 4'hA;
  localparam logic [3:0] F_MINACC = 4'hB;
  localparam logic [3:0] F_MINDEC = 4'hC;
  localparam logic [3:0] F_MINTACC = 4'hD;
  localparam logic [3:0] F_MINTDEC = 4'hE;
  localparam logic [3:0] F_LAST_FENCED = 4'hA;
  localparam int PROFILE_STRIDE = 16;

  // Global register word addresses
  localparam logic [6:0] A_PROFCOUNT = 7'h50;
  localparam logic [6:0] A_CURLIMIT = 7'h51;
  localparam logic [6:0] A_CONTROL = 7'h52;
  localparam logic [6:0] A_OUT_ACCEL = 7'h53;
  localparam logic [6:0] A_OUT_DECEL = 7'h54;
  localparam logic [6:0] A_OUT_TACCEL = 7'h55;
  localparam logic [6:0] A_OUT_TDECEL = 7'h56;
  localparam logic [6:0] A_OUT_FWD = 7'h57;
  localparam logic [6:0] A_OUT_REV = 7'h58;
  localparam logic [6:0] A_OUT_TURN = 7'h59;
  localparam logic [6:0] A_OUT_CUR = 7'h5A;

  // Control register field positions
  localparam int CTL_SPEED_LSB = 0;
  localparam int CTL_PROF_LSB = 4;

  // Value ranges and reset values
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [2:0] SPEED_MIN = 3'h1;
  localparam logic [2:0] SPEED_MAX = 3'h5;
  localparam logic [2:0] PROFILES_MIN = 3'h2;
  localparam logic [2:0] PROFILES_MAX = 3'h5;
  localparam logic [2:0] FULL_STEP = 3'h4;
  localparam logic [6:0] RST_PARAM = 7'h32;
  localparam logic [7:0] RST_CURLIMIT = 8'h3C;
  localparam logic [2:0] RST_PROFCOUNT = 3'h0;
  localparam logic [2:0] RST_SPEED = 3'h1;
  localparam logic [6:0] RST_FENCE_MIN = 7'h00;
  localparam logic [6:0] RST_FENCE_MAX = 7'h64;

endpackage : drive_profile_pkg

// ===== drive_profile_scaler.sv
`timescale 1ns/1ns

// How it works
// (R1) Count zero: one set, buttons step speed
// (R2) Count two to five: buttons select profile
// (R3) Count one: single set, speed buttons ignored
// (R4) Acceleration 0..100, full value at setting five
// (R5) Deceleration 0..100, full value at setting five
// (R6) Turn acceleration 0..100, scaled below setting five
// (R7) Turn deceleration 0..100, scaled below setting five
// (R8) Setting one acceleration: programmed times minimum percent
// (R9) Settings two to four interpolate linearly
// (R10) Setting one deceleration: programmed times minimum percent
// (R11) Setting one turn acceleration: programmed times percent
// (R12) Setting one turn deceleration: programmed times percent
// (R13) Forward speed min at one, max at five
// (R14) Reverse speed min at one, max at five
// (R15) Turning speed min at one, max at five
// (R16) Current limit scaled by power percentage
// (R17) Power stored per profile, selected one applied
// (R18) Fenced parameters clamped to manufacture fences
// (R19) Default fences are 0 and 100
// (R20) Speed setting 1..5, steps by one, saturates
// (R21) Profile index saturates, never wraps
module drive_profile_scaler
  import drive_profile_pkg::*;
#(
  parameter logic [6:0] FENCE_MIN = RST_FENCE_MIN, // Fixed at manufacture [R19]
  parameter logic [6:0] FENCE_MAX = RST_FENCE_MAX
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // User buttons, held high while pressed
  input wire logic speedUpBtn,
  input wire logic speedDownBtn,
  // Demand limits to the motor drive
  output logic [PAR_W-1:0] accelOut,
  output logic [PAR_W-1:0] decelOut,
  output logic [PAR_W-1:0] turnAccelOut,
  output logic [PAR_W-1:0] turnDecelOut,
  // Speed limits in percent
  output logic [PAR_W-1:0] fwdSpeedOut,
  output logic [PAR_W-1:0] revSpeedOut,
  output logic [PAR_W-1:0] turnSpeedOut,
  // Current limit in amps
  output logic [CUR_W-1:0] currentLimitOut,
  // Present selection, for the display
  output logic [2:0] speedSettingOut,
  output logic [2:0] profileOut
);

  // Whole module state in one record
  // One record keeps reset and update in one place each
  typedef struct packed {
    // Programmed settings, one slot per profile
    logic [MAX_PROFILES-1:0][NUM_FIELDS-1:0][PAR_W-1:0] par; // Parameter sets
    logic [2:0] profCount;       // Number of drive profiles, 0..5
    logic [CUR_W-1:0] curLimit;  // Full current limit in amps
    // Selection made by the buttons or the bus
    logic [2:0] speedSet;        // Speed setting, 1..5
    logic [2:0] profSel;         // Selected profile, 0-based
    logic upPrev;                // Button history for edge detection
    logic downPrev;
    // Bus handshake and read capture
    logic ack;                   // Bus answer cycle
    logic [31:0] rdata;          // Captured read data
    // Effective demands, registered so the drive sees clean levels
    logic [PAR_W-1:0] accel;
    logic [PAR_W-1:0] decel;
    logic [PAR_W-1:0] tAccel;
    logic [PAR_W-1:0] tDecel;
    logic [PAR_W-1:0] fwd;
    logic [PAR_W-1:0] rev;
    logic [PAR_W-1:0] turn;
    logic [CUR_W-1:0] cur;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Clamp a written value to the given window
  // Out-of-range writes are pulled to the nearest bound, not refused
  function automatic logic [PAR_W-1:0] clampTo(input logic [31:0] v,
                                                input logic [PAR_W-1:0] lo,
                                                input logic [PAR_W-1:0] hi);
    if (v < {25'h0, lo})
      return lo;
    else if (v > {25'h0, hi})
      return hi;
    else
      return v[PAR_W-1:0];
  endfunction : clampTo

  // Percentage of a value, truncated
  // Truncation means a small product can drop to zero
  function automatic logic [PAR_W-1:0] pctOf(input logic [PAR_W-1:0] v,
                                              input logic [PAR_W-1:0] pct);
    logic [13:0] prod;
    logic [13:0] quot;
    prod = v * pct;
    quot = prod / 14'(PCT_FULL);
    return quot[PAR_W-1:0];
  endfunction : pctOf

  // Linear step from lo (step 0) to hi (step 4), equal quarters
  // Quarters give the four gaps between settings one and five
  // Works both ways, so a minimum above its maximum still ramps
  // Ten bits hold the span times four without loss
  function automatic logic [PAR_W-1:0] interp(input logic [PAR_W-1:0] lo,
                                               input logic [PAR_W-1:0] hi,
                                               input logic [2:0] step);
    logic [9:0] span;
    logic [9:0] part;
    span = 10'(hi >= lo ? hi - lo : lo - hi);
    part = (span * 10'(step)) >> 2;
    if (hi >= lo)
      return lo + part[PAR_W-1:0];
    else
      return lo - part[PAR_W-1:0];
  endfunction : interp

  // Rate whose setting-one value is a percentage of the full value
  // Shared by all four rates so they scale alike
  function automatic logic [PAR_W-1:0] scaledRate(input logic [PAR_W-1:0] full,
                                                   input logic [PAR_W-1:0] minPct,
                                                   input logic [2:0] step);
    return interp(pctOf(full, minPct), full, step);
  endfunction : scaledRate

  // Fenced fields get the manufacture window, the rest 0..100
  // Minimum percentages are not fenced, only held to 0..100
  function automatic logic [PAR_W-1:0] fieldClamp(input logic [3:0] f,
                                                   input logic [31:0] v);
    if (f <= F_LAST_FENCED)
      return clampTo(v, FENCE_MIN, FENCE_MAX);
    else
      return clampTo(v, 7'h00, PCT_FULL);
  endfunction : fieldClamp

  // Decode helpers
  // Mode and selection
  logic profMode;
  logic [2:0] setIdx;
  logic [2:0] step;
  // Button edges
  logic upPress;
  logic downPress;
  // Bus decode
  logic wrEn;
  logic [2:0] pIdx;
  logic [3:0] fIdx;
  logic inProfiles;
  // Current limit product, wide enough for full scale
  logic [CUR_W+PAR_W-1:0] curProd;
  logic [CUR_W+PAR_W-1:0] curQuot;
  // Read data before capture
  logic [31:0] rdMux;

  // Next-state logic
  // One pass computes buttons, bus and demands from the present state
  always_comb
  begin
    // Hold everything unless a branch below moves it
    st_d = st_q;
    profMode = st_q.profCount >= PROFILES_MIN; // [R2]
    setIdx = profMode ? st_q.profSel : 3'h0; // Single set lives in slot zero [R1]
    // Profiles carry their own maxima, so a profile always runs at full step
    step = profMode ? FULL_STEP : st_q.speedSet - SPEED_MIN;
    // A press counts once, on the rising edge of its level
    upPress = speedUpBtn & ~st_q.upPrev;
    downPress = speedDownBtn & ~st_q.downPrev;
    st_d.upPrev = speedUpBtn;
    st_d.downPrev = speedDownBtn;

    // Buttons: profile select, speed step, or nothing
    // Both buttons in one cycle count as neither
    if (profMode)
    begin
      // Profile mode: buttons walk the profile list
      if (upPress && !downPress && st_q.profSel < st_q.profCount - 3'h1)
        st_d.profSel = st_q.profSel + 3'h1; // [R2] [R21]
      else if (downPress && !upPress && st_q.profSel != 3'h0)
        st_d.profSel = st_q.profSel - 3'h1; // [R21]
    end
    else if (st_q.profCount == RST_PROFCOUNT)
    begin
      // Single set: buttons walk the speed setting
      if (upPress && !downPress && st_q.speedSet < SPEED_MAX)
        st_d.speedSet = st_q.speedSet + 3'h1; // [R1] [R20]
      else if (downPress && !upPress && st_q.speedSet > SPEED_MIN)
        st_d.speedSet = st_q.speedSet - 3'h1; // [R20]
    end
    // Count of one: buttons leave the speed setting alone [R3]

    // Bus slave: one wait cycle, then answer
    // Profile slots sit sixteen words apart; field fifteen is unused
    pIdx = 3'h0;
    fIdx = address[3:0];
    inProfiles = 1'b0;
    // A loop over slots keeps the decode free of a divider
    for (int p = 0; p < MAX_PROFILES; p++)
    begin
      if (address[ADDR_W-1:4] == 3'(p) && fIdx < 4'(NUM_FIELDS))
      begin
        inProfiles = 1'b1;
        pIdx = 3'(p);
      end
    end
    // The first request cycle sets ack and writes nothing, so every access waits once
    wrEn = write & st_q.ack;
    st_d.ack = (read | write) & ~st_q.ack;

    // Writes take effect on the answering edge
    if (wrEn)
    begin
      // Clamped on the way in, so readback shows what is used
      if (inProfiles)
        st_d.par[pIdx][fIdx] = fieldClamp(fIdx, writedata); // [R18]
      // Counts above the largest are held at it
      else if (address == A_PROFCOUNT)
        st_d.profCount = writedata > 32'(PROFILES_MAX) ? PROFILES_MAX : writedata[2:0];
      // Current limit taken whole, no fence applies
      else if (address == A_CURLIMIT)
        st_d.curLimit = writedata[CUR_W-1:0];
      // Speed written here wins over a button press
      else if (address == A_CONTROL)
        st_d.speedSet = 3'(clampTo(32'(writedata[CTL_SPEED_LSB +: 3]),
                                   7'(SPEED_MIN), 7'(SPEED_MAX))); // [R20]
    end

    // Keep the selection inside the available profiles [R21]
    // Also covers a count lowered below the selected profile
    if (st_d.profCount < PROFILES_MIN)
      st_d.profSel = 3'h0;
    else if (st_d.profSel >= st_d.profCount)
      st_d.profSel = st_d.profCount - 3'h1;

    // Read mux, unmapped words read zero
    rdMux = 32'h0000_0000;
    if (inProfiles)
      rdMux = 32'(st_q.par[pIdx][fIdx]);
    else
    begin
      case (address)
        A_PROFCOUNT: rdMux = 32'(st_q.profCount);
        A_CURLIMIT: rdMux = 32'(st_q.curLimit);
        // Selection and speed share one word
        A_CONTROL: rdMux = 32'({st_q.profSel, 1'b0, st_q.speedSet});
        A_OUT_ACCEL: rdMux = 32'(st_q.accel);
        A_OUT_DECEL: rdMux = 32'(st_q.decel);
        A_OUT_TACCEL: rdMux = 32'(st_q.tAccel);
        A_OUT_TDECEL: rdMux = 32'(st_q.tDecel);
        A_OUT_FWD: rdMux = 32'(st_q.fwd);
        A_OUT_REV: rdMux = 32'(st_q.rev);
        A_OUT_TURN: rdMux = 32'(st_q.turn);
        A_OUT_CUR: rdMux = 32'(st_q.cur);
        default: rdMux = 32'h0000_0000;
      endcase
    end
    // Captured in the first cycle, handed over in the answer cycle
    if (read && !st_q.ack)
      st_d.rdata = rdMux;

    // Demands use the state before this edge, so they lag by one cycle
    // Speed setting one is step zero, setting five step four
    // Effective rates: setting five gives the programmed value [R4] [R5]
    st_d.accel = scaledRate(st_q.par[setIdx][F_ACCEL],
                            st_q.par[setIdx][F_MINACC], step); // [R8] [R9]
    st_d.decel = scaledRate(st_q.par[setIdx][F_DECEL],
                            st_q.par[setIdx][F_MINDEC], step); // [R10] [R9]
    st_d.tAccel = scaledRate(st_q.par[setIdx][F_TACCEL],
                             st_q.par[setIdx][F_MINTACC], step); // [R6] [R11] [R9]
    st_d.tDecel = scaledRate(st_q.par[setIdx][F_TDECEL],
                             st_q.par[setIdx][F_MINTDEC], step); // [R7] [R12] [R9]

    // Speeds run from their minimum to their maximum
    // No percentage here: the minimum is programmed directly
    st_d.fwd = interp(st_q.par[setIdx][F_FWDMIN],
                      st_q.par[setIdx][F_FWDMAX], step); // [R13]
    st_d.rev = interp(st_q.par[setIdx][F_REVMIN],
                      st_q.par[setIdx][F_REVMAX], step); // [R14]
    st_d.turn = interp(st_q.par[setIdx][F_TURNMIN],
                       st_q.par[setIdx][F_TURNMAX], step); // [R15]

    // Current limit scaled by the selected profile's power [R16] [R17]
    // Wider product so a full limit at full power cannot overflow
    curProd = st_q.curLimit * st_q.par[setIdx][F_POWER];
    curQuot = curProd / 15'(PCT_FULL);
    st_d.cur = curQuot[CUR_W-1:0];
  end

  // Register the whole state; all fields reset to constants
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      // Clear all, then load the non-zero reset values
      // Selection, button history and handshake stay cleared
      st_q <= '0;
      // Every stored field starts at the middle of its range
      for (int p = 0; p < MAX_PROFILES; p++)
      begin
        for (int f = 0; f < NUM_FIELDS; f++)
        begin
          st_q.par[p][f] <= RST_PARAM;
        end
      end
      st_q.curLimit <= RST_CURLIMIT;
      st_q.profCount <= RST_PROFCOUNT;
      st_q.speedSet <= RST_SPEED;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs
  // Wait only while a request is pending and not yet answered
  assign waitrequest = (read | write) & ~st_q.ack;
  assign readdata = st_q.rdata;
  // Demand limits straight from their flip-flops
  assign accelOut = st_q.accel;
  assign decelOut = st_q.decel;
  assign turnAccelOut = st_q.tAccel;
  assign turnDecelOut = st_q.tDecel;
  assign fwdSpeedOut = st_q.fwd;
  assign revSpeedOut = st_q.rev;
  assign turnSpeedOut = st_q.turn;
  assign currentLimitOut = st_q.cur;
  assign speedSettingOut = st_q.speedSet;
  assign profileOut = st_q.profSel;

endmodule : drive_profile_scaler

// ===== drive_profile_scaler_assertions.sv
`timescale 1ns/1ns
module drive_profile_checker
  import drive_profile_pkg::*;
#(
  parameter logic [6:0] FENCE_MIN = RST_FENCE_MIN,
  parameter logic [6:0] FENCE_MAX = RST_FENCE_MAX
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Buttons and demands
  input wire logic speedUpBtn,
  input wire logic speedDownBtn,
  input wire logic [PAR_W-1:0] accelOut,
  input wire logic [PAR_W-1:0] fwdSpeedOut,
  input wire logic [2:0] speedSettingOut,
  input wire logic [2:0] profileOut
);
  // One domain, so clock and reset are stated once
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Exactly one wait cycle per held request
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait cycle");
  // Idle bus never stalls
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised with no request");
  a_speed_range: assert property (speedSettingOut inside {[SPEED_MIN:SPEED_MAX]})
    else $error("speed setting out of range");
  // Without a bus write the setting moves by one only
  a_speed_step: assert property ($changed(speedSettingOut) && !$past(write) |->
    speedSettingOut == $past(speedSettingOut) + 3'h1 ||
    speedSettingOut == $past(speedSettingOut) - 3'h1) else $error("speed jumped");
  a_speed_top: assert property ($rose(speedUpBtn) && !speedDownBtn && !write &&
    speedSettingOut == SPEED_MAX |=> speedSettingOut == SPEED_MAX) else $error("top wrapped");
  a_speed_floor: assert property ($rose(speedDownBtn) && !speedUpBtn && !write &&
    speedSettingOut == SPEED_MIN |=> speedSettingOut == SPEED_MIN) else $error("floor wrapped");
  a_prof_bound: assert property (profileOut <= PROFILES_MAX - 3'h1)
    else $error("profile index beyond last");
  // Interpolation never goes past the fenced full value
  a_rate_fence: assert property (accelOut <= FENCE_MAX && fwdSpeedOut <= FENCE_MAX)
    else $error("demand above fence");
  // Read data is captured one edge before it is handed over
  a_accel_read: assert property (read && !waitrequest && address == A_OUT_ACCEL |->
    readdata == {25'h0, $past(accelOut)}) else $error("accel readback wrong");
  a_ctl_read: assert property (read && !waitrequest && address == A_CONTROL |->
    readdata[6:0] == {$past(profileOut), 1'h0, $past(speedSettingOut)})
    else $error("control readback wrong");
  // Main scenarios reached
  c_top: cover property (speedSettingOut == SPEED_MAX);
  c_prof: cover property (profileOut == 3'h2);
  c_read: cover property (read && !waitrequest);
endmodule : drive_profile_checker

bind drive_profile_scaler drive_profile_checker #(.FENCE_MIN(FENCE_MIN), .FENCE_MAX(FENCE_MAX))
  i_check (.clock, .rst_n, .address, .read, .write, .readdata, .waitrequest, .speedUpBtn,
  .speedDownBtn, .accelOut, .fwdSpeedOut, .speedSettingOut, .profileOut);

// ===== drive_profile_scaler_bench.sv
`timescale 1ns/1ns
module drive_profile_scaler_bench;
  import drive_profile_pkg::*;
  logic clock = 1'h0; // Stimulus
  logic rst_n = 1'h0;
  logic [6:0] address = 7'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0000_0000;
  logic upCmd = 1'h0;
  logic downCmd = 1'h0;
  logic speedUpBtn, speedDownBtn, waitrequest; // Observed
  logic [31:0] readdata, rd;
  logic [6:0] accelOut, decelOut, turnAccelOut, turnDecelOut;
  logic [6:0] fwdSpeedOut, revSpeedOut, turnSpeedOut;
  logic [7:0] currentLimitOut;
  logic [2:0] speedSettingOut, profileOut;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Rows: write flag, word address, write data or expected read
  logic [15:0] rows [54] = '{16'h5319, 16'h5A1E, 16'h5000, 16'h5201,
    16'h8050, 16'h8B19, 16'h8150, 16'h8C19, 16'h8250, 16'h8D19, 16'h8350, 16'h8E19,
    16'h840A, 16'h855A, 16'h8600, 16'h8764, 16'h8814, 16'h893C, 16'h8A32, 16'hD1C8,
    16'hD201, 16'h5314, 16'h5414, 16'h570A, 16'h5800, 16'h5A64, 16'hD202, 16'h5423, 16'h571E,
    16'hD203, 16'h5532, 16'h5632, 16'h5732, 16'h5928, 16'hD204, 16'h5341, 16'h5204, 16'h5746,
    16'hD205, 16'h5550, 16'h5650, 16'h575A, 16'h5864, 16'hD355, 16'h5350,
    16'h8078, 16'h0064, 16'h8BFF, 16'h0B64, 16'hFF11, 16'h7F00,
    16'hD007, 16'h5005, 16'hD000};
  always #20 clock = ~clock;
  button_panel i_panel (.clock, .upCmd, .downCmd, .speedUpBtn, .speedDownBtn);
  drive_profile_scaler i_dut (.clock, .rst_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .speedUpBtn, .speedDownBtn, .accelOut, .decelOut, .turnAccelOut,
    .turnDecelOut, .fwdSpeedOut, .revSpeedOut, .turnSpeedOut, .currentLimitOut,
    .speedSettingOut, .profileOut);
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bus cycle held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
    output logic [31:0] q);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    // One idle edge so the next call never reassigns in this step
    @(posedge clock);
  endtask : bus
  // One button press, then time for the demands to settle
  task automatic press(input logic up);
    upCmd <= up;
    downCmd <= !up;
    @(posedge clock);
    upCmd <= 1'h0;
    downCmd <= 1'h0;
    repeat (6) @(posedge clock);
  endtask : press
  task automatic do_reset;
    rst_n <= 1'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
  endtask : do_reset
  task automatic tally_and_finish;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Cut a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    do_reset();
    // Table: reset values, interpolation per setting, fences, unmapped places
    foreach (rows[i])
    begin
      bus(rows[i][15], rows[i][14:8], {24'h0, rows[i][7:0]}, rd);
      if (!rows[i][15])
        check(rd, {24'h0, rows[i][7:0]});
    end
    $display("table done");
    // Buttons step the setting and saturate at both ends
    press(1'h1);
    check({29'h0, speedSettingOut}, 32'h0000_0005);
    repeat (5) press(1'h0);
    check({29'h0, speedSettingOut}, 32'h0000_0001);
    press(1'h1);
    check({29'h0, speedSettingOut}, 32'h0000_0002);
    // Count one freezes the setting
    bus(1'h1, A_PROFCOUNT, 32'h0000_0001, rd);
    press(1'h1);
    check({29'h0, speedSettingOut}, 32'h0000_0002);
    $display("speed buttons done");
    // Three profiles, own power each, full-step demands
    bus(1'h1, 7'h1A, 32'h0000_0064, rd);
    bus(1'h1, A_PROFCOUNT, 32'h0000_0003, rd);
    press(1'h0);
    check({29'h0, profileOut}, 32'h0000_0000);
    check({24'h0, currentLimitOut}, 32'h0000_0064);
    check({25'h0, accelOut}, 32'h0000_0064);
    check({25'h0, fwdSpeedOut}, 32'h0000_005A);
    check({25'h0, revSpeedOut}, 32'h0000_0064);
    check({25'h0, turnSpeedOut}, 32'h0000_003C);
    check({25'h0, decelOut}, 32'h0000_0050);
    check({25'h0, turnAccelOut}, 32'h0000_0050);
    check({25'h0, turnDecelOut}, 32'h0000_0050);
    press(1'h1);
    check({29'h0, profileOut}, 32'h0000_0001);
    check({24'h0, currentLimitOut}, 32'h0000_00C8);
    check({25'h0, accelOut}, 32'h0000_0032);
    press(1'h1);
    press(1'h1);
    check({29'h0, profileOut}, 32'h0000_0002);
    $display("profiles done");
    // Reset in mid-run restores the reset values
    do_reset();
    bus(1'h0, 7'h00, 32'h0000_0000, rd);
    check(rd, 32'h0000_0032);
    bus(1'h0, A_PROFCOUNT, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    check({25'h0, accelOut}, 32'h0000_0019);
    check({24'h0, currentLimitOut}, 32'h0000_001E);
    check({25'h0, fwdSpeedOut}, 32'h0000_0032);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : drive_profile_scaler_bench
